// *** sep_port_ddr_sram_burst4_consts.svh ***
// Constants for the separate-port burst-of-four DDR SRAM core
`ifndef SEP_PORT_DDR_SRAM_BURST4_CONSTS_SVH
`define SEP_PORT_DDR_SRAM_BURST4_CONSTS_SVH

// Address and data organisation
`define ADDR_BITS 20
`define WORD_BITS 18
`define BURST_WORDS 4
`define LANES 2
// Lane 0 covers bits 8..0, lane 1 covers bits 17..9
`define LANE0_BITS 9
`define LANE1_LSB 9
`define LANE1_BITS 9

// Pending-write buffer and array write timing
`define WBUF_DEPTH 32
`define WR_RECOVERY_CYCLES 2

`endif

// *** sep_port_ddr_sram_burst4_pkg.sv ***
// Types shared by the separate-port burst-of-four DDR SRAM core
package sep_port_ddr_sram_burst4_pkg;

  // Which port owns the address bus on the current positive edge
  typedef enum logic {
    SLOT_READ = 1'b0,
    SLOT_WRITE = 1'b1
  } addr_slot_e;

  // Self-timed array write engine
  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_RECOVER = 1'b1
  } wr_engine_e;

endpackage

// *** wbuf_fifo.sv ***
// Pending-write FIFO with a snoop view of its contents for read coherency
`timescale 1ns/1ps
module wbuf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int PTR_W = $clog2(DEPTH)
)(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filling side
  input wire logic in_valid,
  output wire logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output wire logic out_valid,
  input wire logic out_ready,
  output wire logic [WIDTH-1:0] out_data,
  // Snoop view: raw storage, oldest slot and fill level
  output logic [DEPTH*WIDTH-1:0] snoop_flat,
  output wire logic [PTR_W-1:0] snoop_rd_ptr,
  output wire logic [PTR_W:0] snoop_count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;

  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;

  assign in_ready = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign snoop_rd_ptr = rd_ptr_q;
  assign snoop_count = count_q;

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      snoop_flat[i*WIDTH +: WIDTH] = mem[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule

// *** sep_port_ddr_sram_burst4.sv ***
// Separate read/write port burst-of-four DDR SRAM core
`timescale 1ns/1ps
`include "sep_port_ddr_sram_burst4_consts.svh"
module sep_port_ddr_sram_burst4 #(
  parameter int ADDR_W = `ADDR_BITS,
  parameter int WORD_W = `WORD_BITS,
  parameter int WBUF_DEPTH = `WBUF_DEPTH,
  parameter int WR_RECOVERY = `WR_RECOVERY_CYCLES
)(
  // System clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Input clock pair
  input wire logic k_clk,
  input wire logic k_clk_n,
  // Latency mode pin
  input wire logic pll_off_select,
  // Shared address bus and port selects
  input wire logic [ADDR_W-1:0] address,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  // Write data port
  input wire logic [WORD_W-1:0] write_data,
  input wire logic [`LANES-1:0] byte_lane_select_n,
  // Read data port
  output wire logic [WORD_W-1:0] read_data,
  output wire logic read_data_oe,
  output wire logic output_valid_flag,
  // Echo clocks
  output wire logic echo_clock_out,
  output wire logic echo_clock_out_n,
  // Pending-write buffer has room
  output logic write_buffer_ready
);
  import sep_port_ddr_sram_burst4_pkg::*;

  localparam int BURST_W = WORD_W * `BURST_WORDS;
  localparam int MASK_W = `LANES * `BURST_WORDS;
  localparam int ENTRY_W = ADDR_W + MASK_W + BURST_W;
  localparam int PTR_W = $clog2(WBUF_DEPTH);

  // Apply one buffered write to a burst when its address matches
  function automatic logic [BURST_W-1:0] merge_entry(
    input logic [BURST_W-1:0] cur,
    input logic [ENTRY_W-1:0] ent,
    input logic [ADDR_W-1:0] addr
  );
    logic [BURST_W-1:0] res;
    logic [MASK_W-1:0] msk;
    res = cur;
    msk = ent[BURST_W +: MASK_W];
    if (ent[ENTRY_W-1 -: ADDR_W] == addr)
    begin
      for (int k = 0; k < `BURST_WORDS; k++)
      begin
        if (msk[k*`LANES])
        begin
          res[k*WORD_W +: `LANE0_BITS] = ent[k*WORD_W +: `LANE0_BITS];
        end
        if (msk[k*`LANES+1])
        begin
          res[k*WORD_W+`LANE1_LSB +: `LANE1_BITS] =
            ent[k*WORD_W+`LANE1_LSB +: `LANE1_BITS];
        end
      end
    end
    return res;
  endfunction

  // Pick word k out of a burst
  function automatic logic [WORD_W-1:0] burst_word(
    input logic [BURST_W-1:0] b,
    input int k
  );
    return b[k*WORD_W +: WORD_W];
  endfunction

  // Reset and mode pin cross into the K domain
  logic reset_sys_q;
  logic rst_meta_q;
  logic rst_k_q;
  logic pll_off_select_meta_q;
  logic pll_off_select_q;

  always_ff @(posedge clk_sys)
  begin
    reset_sys_q <= reset;
  end

  always_ff @(posedge k_clk)
  begin
    rst_meta_q <= reset_sys_q;
    rst_k_q <= rst_meta_q;
    pll_off_select_meta_q <= pll_off_select;
    pll_off_select_q <= pll_off_select_meta_q;
  end

  // Address slot and port select decode
  addr_slot_e slot_q;
  wire logic rd_go = (slot_q == SLOT_READ) && !read_port_select_n;
  wire logic wr_go = (slot_q == SLOT_WRITE) && !write_port_select_n;

  // Read pipeline: stage 1 holds the address, 2..4 hold the burst
  logic rd_v1_q;
  logic rd_v2_q;
  logic rd_v3_q;
  logic rd_v4_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [BURST_W-1:0] rd_b2_q;
  logic [BURST_W-1:0] rd_b3_q;
  logic [BURST_W-1:0] rd_b4_q;

  // Write pipeline: address, then words 0, then 0..2, then push with 3
  logic wr_v0_q;
  logic wr_v1_q;
  logic wr_v2_q;
  logic [ADDR_W-1:0] wr_a0_q;
  logic [ADDR_W-1:0] wr_a1_q;
  logic [ADDR_W-1:0] wr_a2_q;
  logic [WORD_W-1:0] wr_w0_q;
  logic [`LANES-1:0] wr_m0_q;
  logic [3*WORD_W-1:0] wr_w012_q;
  logic [3*`LANES-1:0] wr_m012_q;
  logic [WORD_W-1:0] in_fall_word_q;
  logic [`LANES-1:0] in_fall_mask_q;

  always_ff @(posedge k_clk)
  begin
    if (rst_k_q)
    begin
      slot_q <= SLOT_READ;
      rd_v1_q <= 1'b0;
      wr_v0_q <= 1'b0;
    end
    else
    begin
      slot_q <= (slot_q == SLOT_READ) ? SLOT_WRITE : SLOT_READ;
      rd_v1_q <= rd_go;
      wr_v0_q <= wr_go;
    end
  end

  // Address is only taken for a selected port
  always_ff @(posedge k_clk)
  begin
    if (rd_go)
    begin
      rd_addr_q <= address;
    end
    if (wr_go)
    begin
      wr_a0_q <= address;
    end
  end

  // Words on K-bar rising edges; lane enables kept active high
  always_ff @(posedge k_clk_n)
  begin
    in_fall_word_q <= write_data;
    in_fall_mask_q <= ~byte_lane_select_n;
  end

  always_ff @(posedge k_clk)
  begin
    if (rst_k_q)
    begin
      wr_v1_q <= 1'b0;
      wr_v2_q <= 1'b0;
    end
    else
    begin
      wr_v1_q <= wr_v0_q;
      wr_v2_q <= wr_v1_q;
    end
  end

  // Burst assembly from alternating K and K-bar words
  always_ff @(posedge k_clk)
  begin
    wr_a1_q <= wr_a0_q;
    wr_w0_q <= write_data;
    wr_m0_q <= ~byte_lane_select_n;
    wr_a2_q <= wr_a1_q;
    wr_w012_q <= {write_data, in_fall_word_q, wr_w0_q};
    wr_m012_q <= {~byte_lane_select_n, in_fall_mask_q, wr_m0_q};
  end

  // Completed write burst goes to the pending-write buffer
  wire logic [ENTRY_W-1:0] push_entry =
    {wr_a2_q, in_fall_mask_q, wr_m012_q, in_fall_word_q, wr_w012_q};
  wire logic push_valid = wr_v2_q;
  wire logic push_ready;
  wire logic pop_valid;
  wire logic [ENTRY_W-1:0] pop_entry;
  wire logic [WBUF_DEPTH*ENTRY_W-1:0] snoop_flat;
  wire logic [PTR_W-1:0] snoop_rd_ptr;
  wire logic [PTR_W:0] snoop_count;
  wr_engine_e eng_q;
  logic [7:0] rec_cnt_q;
  wire logic pop_ready = (eng_q == ENG_IDLE);

  wbuf_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(WBUF_DEPTH),
    .PTR_W(PTR_W)
  ) u_wbuf (
    .clk(k_clk),
    .reset(rst_k_q),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_entry),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_entry),
    .snoop_flat(snoop_flat),
    .snoop_rd_ptr(snoop_rd_ptr),
    .snoop_count(snoop_count)
  );

  // Memory array, one burst per address
  logic [BURST_W-1:0] array_mem [2**ADDR_W];
  wire logic [ADDR_W-1:0] pop_addr = pop_entry[ENTRY_W-1 -: ADDR_W];
  wire logic pop_fire = pop_valid && pop_ready;

  // Self-timed write: one entry, then a recovery gap before the next
  always_ff @(posedge k_clk)
  begin
    if (pop_fire)
    begin
      array_mem[pop_addr] <=
        merge_entry(array_mem[pop_addr], pop_entry, pop_addr);
    end
  end

  always_ff @(posedge k_clk)
  begin
    if (rst_k_q)
    begin
      eng_q <= ENG_IDLE;
      rec_cnt_q <= 8'h00;
    end
    else
    begin
      case (eng_q)
        ENG_IDLE:
        begin
          if (pop_fire && WR_RECOVERY > 1)
          begin
            eng_q <= ENG_RECOVER;
            rec_cnt_q <= 8'(WR_RECOVERY - 1);
          end
        end
        ENG_RECOVER:
        begin
          rec_cnt_q <= rec_cnt_q - 8'h01;
          if (rec_cnt_q == 8'h01)
          begin
            eng_q <= ENG_IDLE;
          end
        end
        default:
        begin
          eng_q <= ENG_IDLE;
        end
      endcase
    end
  end

  // Coherent read: array, then buffered writes oldest first, then push
  logic [BURST_W-1:0] rd_now;
  always_comb
  begin
    logic [PTR_W-1:0] idx;
    idx = '0;
    rd_now = array_mem[rd_addr_q];
    for (int i = 0; i < WBUF_DEPTH; i++)
    begin
      idx = snoop_rd_ptr + PTR_W'(i);
      if ((PTR_W+1)'(i) < snoop_count)
      begin
        rd_now = merge_entry(rd_now,
          snoop_flat[idx*ENTRY_W +: ENTRY_W], rd_addr_q);
      end
    end
    if (push_valid && push_ready)
    begin
      rd_now = merge_entry(rd_now, push_entry, rd_addr_q);
    end
  end

  always_ff @(posedge k_clk)
  begin
    if (rst_k_q)
    begin
      rd_v2_q <= 1'b0;
      rd_v3_q <= 1'b0;
      rd_v4_q <= 1'b0;
    end
    else
    begin
      rd_v2_q <= rd_v1_q;
      rd_v3_q <= rd_v2_q;
      rd_v4_q <= rd_v3_q;
    end
  end

  always_ff @(posedge k_clk)
  begin
    rd_b2_q <= rd_now;
    rd_b3_q <= rd_b2_q;
    rd_b4_q <= rd_b3_q;
  end

  // Word launch schedule; reads are at least two cycles apart
  wire logic rise_lo_0 = !pll_off_select_q && rd_v1_q;
  wire logic rise_lo_2 = !pll_off_select_q && rd_v2_q;
  wire logic rise_hi_1 = pll_off_select_q && rd_v3_q;
  wire logic rise_hi_3 = pll_off_select_q && rd_v4_q;
  wire logic fall_lo_1 = !pll_off_select_q && rd_v1_q;
  wire logic fall_lo_3 = !pll_off_select_q && rd_v2_q;
  wire logic fall_hi_0 = pll_off_select_q && rd_v2_q;
  wire logic fall_hi_2 = pll_off_select_q && rd_v3_q;

  // PLL mode: words at K+1, K-bar+1, K+2, K-bar+2
  // Bypass mode: words at K-bar+2, K+3, K-bar+3, K+4
  wire logic rise_valid_d = rise_lo_0 || rise_lo_2 ||
    rise_hi_1 || rise_hi_3;
  wire logic [WORD_W-1:0] rise_word_d =
    rise_lo_0 ? burst_word(rd_now, 0) :
    rise_lo_2 ? burst_word(rd_b2_q, 2) :
    rise_hi_1 ? burst_word(rd_b3_q, 1) :
    rise_hi_3 ? burst_word(rd_b4_q, 3) : '0;
  wire logic fall_valid_d = fall_lo_1 || fall_lo_3 ||
    fall_hi_0 || fall_hi_2;
  wire logic [WORD_W-1:0] fall_word_d =
    fall_lo_1 ? burst_word(rd_now, 1) :
    fall_lo_3 ? burst_word(rd_b2_q, 3) :
    fall_hi_0 ? burst_word(rd_b2_q, 0) :
    fall_hi_2 ? burst_word(rd_b3_q, 2) : '0;

  // Output registers on both rising edges
  logic [WORD_W-1:0] q_rise_q;
  logic v_rise_q;
  logic [WORD_W-1:0] q_fall_pre_q;
  logic v_fall_pre_q;
  logic [WORD_W-1:0] q_fall_q;
  logic v_fall_q;
  logic echo_k_q;
  logic echo_kn_q;

  always_ff @(posedge k_clk)
  begin
    if (rst_k_q)
    begin
      q_rise_q <= '0;
      v_rise_q <= 1'b0;
      q_fall_pre_q <= '0;
      v_fall_pre_q <= 1'b0;
      echo_k_q <= 1'b0;
      write_buffer_ready <= 1'b1;
    end
    else
    begin
      q_rise_q <= rise_word_d;
      v_rise_q <= rise_valid_d;
      q_fall_pre_q <= fall_word_d;
      v_fall_pre_q <= fall_valid_d;
      echo_k_q <= !echo_k_q;
      write_buffer_ready <= push_ready;
    end
  end

  always_ff @(posedge k_clk_n)
  begin
    if (rst_k_q)
    begin
      q_fall_q <= '0;
      v_fall_q <= 1'b0;
      echo_kn_q <= 1'b0;
    end
    else
    begin
      q_fall_q <= q_fall_pre_q;
      v_fall_q <= v_fall_pre_q;
      // Copy the K toggle so the echo rises at K and falls at K-bar
      echo_kn_q <= echo_k_q;
    end
  end

  // Pin mux: K-bar high selects the K-bar launched register
  assign read_data = k_clk_n ? q_fall_q : q_rise_q;
  assign output_valid_flag = k_clk_n ? v_fall_q : v_rise_q;
  assign read_data_oe = k_clk_n ? v_fall_q : v_rise_q;
  assign echo_clock_out = echo_k_q ^ echo_kn_q;
  assign echo_clock_out_n = !(echo_k_q ^ echo_kn_q);
endmodule

// *** sep_port_ddr_sram_burst4_assertions.sv ***
// Checker: read latency, burst framing, idle outputs and echo clocks
`timescale 1ns/1ps
module sep_port_ddr_sram_burst4_chk #(
  parameter int WORD_W = 18
)(
  // Reset and input clocks
  input wire logic reset,
  input wire logic k_clk,
  input wire logic k_clk_n,
  // Request side
  input wire logic pll_off_select,
  input wire logic read_port_select_n,
  // Read port and echo clocks
  input wire logic [WORD_W-1:0] read_data,
  input wire logic read_data_oe,
  input wire logic output_valid_flag,
  input wire logic echo_clock_out,
  input wire logic echo_clock_out_n
);
  // K-bar rise sees the K-launched word and the next K capture inputs
  default clocking cb @(posedge k_clk_n);
  endclocking
  default disable iff (reset);
  logic [3:0] up_q;
  always_ff @(posedge k_clk)
  begin
    if (reset)
      up_q <= 4'h0;
    else if (up_q != 4'hF)
      up_q <= up_q + 4'h1;
  end
  property p_lat_fast;
    !pll_off_select && $rose(output_valid_flag) |-> !$past(read_port_select_n, 2);
  endproperty
  a_lat_fast: assert property (p_lat_fast)
    else $error("fast read latency wrong");
  property p_lat_slow;
    pll_off_select && $rose(output_valid_flag) |-> !$past(read_port_select_n, 4);
  endproperty
  a_lat_slow: assert property (p_lat_slow)
    else $error("slow read latency wrong");
  property p_span_fast;
    !pll_off_select && output_valid_flag
      |-> !$past(read_port_select_n, 2) || !$past(read_port_select_n, 3);
  endproperty
  a_span_fast: assert property (p_span_fast)
    else $error("read word without a read");
  property p_span_slow;
    pll_off_select && output_valid_flag
      |-> !$past(read_port_select_n, 4) || !$past(read_port_select_n, 5);
  endproperty
  a_span_slow: assert property (p_span_slow)
    else $error("slow read word without a read");
  property p_burst;
    $rose(output_valid_flag) |-> output_valid_flag [*2];
  endproperty
  a_burst: assert property (p_burst)
    else $error("read burst cut short");
  property p_idle;
    !output_valid_flag |-> !read_data_oe && read_data == '0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("outputs driven while idle");
  property p_oe;
    output_valid_flag |-> read_data_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("valid word not driven");
  property p_echo;
    up_q == 4'hF |-> echo_clock_out && !echo_clock_out_n;
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo clock pair wrong");
  c_fast: cover property (!pll_off_select && $rose(output_valid_flag));
  c_slow: cover property (pll_off_select && $rose(output_valid_flag));
  c_echo: cover property (up_q == 4'hF);
endmodule
bind sep_port_ddr_sram_burst4 sep_port_ddr_sram_burst4_chk #(
  .WORD_W(WORD_W)
) u_chk (.reset, .k_clk, .k_clk_n, .pll_off_select, .read_port_select_n,
  .read_data, .read_data_oe, .output_valid_flag, .echo_clock_out,
  .echo_clock_out_n);

// *** ddr_ctrl_model.sv ***
// Controller model: input clocks, address slots and write bursts
`timescale 1ns/1ps
module ddr_ctrl_model (
  // Input clock pair
  output logic k_clk,
  output wire logic k_clk_n,
  // Shared address and port selects
  output logic [19:0] address,
  output logic read_port_select_n,
  output logic write_port_select_n,
  // Write data and lanes
  output logic [17:0] write_data,
  output logic [1:0] byte_lane_select_n,
  // Valid flag, used to find the slot phase
  input wire logic output_valid_flag
);
  int kc = 0;
  logic rd_ph = 1'b0;
  assign k_clk_n = ~k_clk;
  initial
  begin
    {address, write_data} = '0;
    {read_port_select_n, write_port_select_n} = 2'h3;
    byte_lane_select_n = 2'h3;
    k_clk = 1'b0;
    #5;
    forever #32 k_clk = ~k_clk;
  end
  always @(posedge k_clk) kc <= kc + 1;
  // Probe one edge with a read to learn which edges are read slots
  task automatic sync_slot();
    @(posedge k_clk) #2 read_port_select_n = 1'b0;
    @(posedge k_clk) #2 read_port_select_n = 1'b1;
    rd_ph = kc[0];
    @(posedge k_clk) #16 if (output_valid_flag !== 1'b1) rd_ph = ~rd_ph;
  endtask
  // Read address in a read slot, write address on the next edge
  task automatic xfer(input logic rd, input logic [19:0] ra,
    input logic wr, input logic [19:0] wa, input logic [71:0] d,
    input logic [7:0] ln);
    @(posedge k_clk) #2;
    if (kc[0] == rd_ph)
      @(posedge k_clk) #2;
    address = ra;
    read_port_select_n = ~rd;
    @(posedge k_clk) #2 address = wa;
    write_port_select_n = ~wr;
    read_port_select_n = 1'b1;
    @(posedge k_clk) #2 address = ~wa;
    write_port_select_n = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      write_data = d[18*k +: 18];
      byte_lane_select_n = ln[2*k +: 2];
      if (k[0])
        @(posedge k_clk_n) #2;
      else
        @(posedge k_clk) #2;
    end
    write_data = ~write_data;
    byte_lane_select_n = ~byte_lane_select_n;
  endtask
endmodule

// *** sep_port_ddr_sram_burst4_tb_top.sv ***
// Testbench: bursts, lanes, concurrent ports and both latency modes
`timescale 1ns/1ps
module sep_port_ddr_sram_burst4_tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic pll_off_select = 1'b0;
  wire logic k_clk, k_clk_n, read_port_select_n, write_port_select_n;
  wire logic read_data_oe, output_valid_flag, write_buffer_ready;
  wire logic echo_clock_out, echo_clock_out_n;
  wire logic [19:0] address;
  wire logic [17:0] write_data, read_data;
  wire logic [1:0] byte_lane_select_n;
  int fails = 0;
  int cmp_count = 0;
  logic live = 1'b0;
  logic [17:0] q [$];
  logic [71:0] mem [3];
  logic [19:0] ad [3] = '{20'h00000, 20'hFFFFF, 20'h5A5A5};
  ddr_ctrl_model u_ctrl (.k_clk, .k_clk_n, .address, .read_port_select_n,
    .write_port_select_n, .write_data, .byte_lane_select_n,
    .output_valid_flag);
  sep_port_ddr_sram_burst4 u_dut (.clk_sys, .reset, .k_clk, .k_clk_n,
    .pll_off_select, .address, .read_port_select_n, .write_port_select_n,
    .write_data, .byte_lane_select_n, .read_data, .read_data_oe,
    .output_valid_flag, .echo_clock_out, .echo_clock_out_n,
    .write_buffer_ready);
  initial
    forever #4 clk_sys = ~clk_sys;
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Collect read words mid-way through each half cycle
  always @(posedge k_clk or posedge k_clk_n)
  begin
    #16;
    if (live)
    begin
      check(18'(echo_clock_out), 18'(k_clk));
      check(18'(echo_clock_out_n), 18'(k_clk_n));
    end
    if (output_valid_flag === 1'b1)
    begin
      check(18'(read_data_oe), 18'h1);
      q.push_back(read_data);
    end
  end
  function automatic logic [71:0] merge(logic [71:0] o, logic [71:0] n,
    logic [7:0] ln);
    logic [71:0] r;
    r = o;
    for (int k = 0; k < 8; k++)
      if (!ln[k])
        r[9*k +: 9] = n[9*k +: 9];
    return r;
  endfunction
  task automatic expect_rd(input int i);
    int n;
    for (n = 0; n < 100 && q.size() < 4; n++)
      @(posedge k_clk);
    if (n == 100)
    begin
      fails++;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
        check(q.pop_front(), mem[i][18*k +: 18]);
      repeat (6) @(posedge k_clk);
      check(18'(q.size()), 18'h0);
    end
  endtask
  task automatic wr(input int i, input logic [71:0] d, input logic [7:0] ln);
    u_ctrl.xfer(1'b0, 20'h00000, 1'b1, ad[i], d, ln);
    mem[i] = merge(mem[i], d, ln);
    check(18'(write_buffer_ready), 18'h1);
  endtask
  // Write data rides along unselected and must be ignored
  task automatic rd(input int i);
    u_ctrl.xfer(1'b1, ad[i], 1'b0, ad[i], ~mem[i], 8'h00);
    expect_rd(i);
  endtask
  task automatic t_burst();
    wr(0, {18'h3FFFF, 18'h00001, 18'h2AAAA, 18'h15555}, 8'h00);
    wr(1, {18'h12345, 18'h0F0F0, 18'h30303, 18'h00000}, 8'h00);
    rd(0);
    rd(1);
  endtask
  task automatic t_lanes();
    wr(0, {4{18'h1E1E1}}, 8'h96);
    rd(0);
  endtask
  task automatic t_both();
    u_ctrl.xfer(1'b1, ad[0], 1'b1, ad[2], {4{18'h0BEEF}}, 8'h00);
    expect_rd(0);
    mem[2] = {4{18'h0BEEF}};
    rd(2);
  endtask
  task automatic t_slow();
    @(negedge clk_sys) pll_off_select = 1'b1;
    repeat (8) @(posedge k_clk);
    rd(1);
    rd(2);
    @(negedge clk_sys) pll_off_select = 1'b0;
    repeat (8) @(posedge k_clk);
  endtask
  initial
  begin
    repeat (10) @(posedge k_clk);
    @(negedge clk_sys) reset = 1'b0;
    repeat (6) @(posedge k_clk);
    u_ctrl.sync_slot();
    live = 1'b1;
    repeat (6) @(posedge k_clk);
    q.delete();
    t_burst();
    t_lanes();
    t_both();
    t_slow();
    report_and_stop();
  end
endmodule
